// >>> rtl/timer_channel_compare_pwm.sv
// Purpose: counter, prescaler and two capture/compare/PWM channels
// Assumes: single clock clk_sys at 10 MHz, synchronous active-high reset
// Notes: channel pins are split into input, output and output enable
//
// Overview of operation
// R1 - buffered_mode_select in channel 0 links both channels onto channel 0 pin
// R2 - linked: channel 0 value rules first; channel 1 takes over at the overflow after its value is written
// R3 - every later overflow hands control to the channel written last
// R4 - linked: channel 0 control governs; channel 1 pin released as plain I/O
// R5 - writing the active channel's value acts immediately, like unbuffered compare
// R6 - software should only write the inactive channel's value when linked
// R7 - toggle-on-overflow flips the pin at modulo, giving the PWM period
// R8 - pulse width runs from overflow to the next compare match
// R9 - software picks clear-on-compare for high pulse, set for low pulse
// R10 - modulo 0x00ff with prescaler zero gives a 256-clock period
// R11 - 8-bit PWM: value 0x0080 in period 256 gives half duty
// R12 - capture mode sets the flag on the selected active pin edge
// R13 - compare mode sets the flag when counter equals compare value
// R14 - flag clears by read-while-set then write 0; new event voids the write
// R15 - reset clears flags; writing 1 to a flag does nothing
// R16 - per-channel interrupt enable, cleared by reset
// R17 - control selects mode, edge, output action, overflow toggle, full duty, buffering
// R18 - interrupt request raised while flag and enable are both set

`timescale 1ns/1ps
`default_nettype none

module timer_channel_compare_pwm (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// register port
	input wire timer_channel_pkg::bus_req_t bus,
	output logic [7:0] rdata,
	// channel pins, index 0 is channel0_pin, index 1 is channel1_pin
	input wire logic [1:0] channel_pin_in,
	output logic [1:0] channel_pin_out,
	output logic [1:0] channel_pin_oe,
	// interrupt requests
	output logic [1:0] irq
);

	// ********************************
	// state and next values
	// ********************************
	logic [6:0] pre, next_pre;
	logic [2:0] ps, next_ps;
	logic [15:0] cnt, next_cnt;
	logic [15:0] modv, next_modv;
	timer_channel_pkg::chan_ctl_t ctl [2];
	timer_channel_pkg::chan_ctl_t next_ctl [2];
	logic [15:0] ccv [2];
	logic [15:0] next_ccv [2];
	logic [1:0] arm, next_arm;
	logic active, next_active;
	logic last_wr, next_last_wr;
	logic [1:0] s1, s2, s3, st, next_st;
	logic [1:0] next_pin_out, next_pin_oe, next_irq;
	logic [7:0] next_rdata;

	// per-cycle events
	logic tick, ovf, linked;
	logic [6:0] mask;
	logic [1:0] rise, fall, match, cap, evt, en;
	logic [15:0] ccv_eff [2];
	logic [15:0] cnt_step;

	// ********************************
	// next-value logic
	// ********************************
	always_comb begin
		// prescaler and counter
		mask = 7'((8'h01 << ps) - 8'h01);
		tick = ((pre & mask) == mask);
		ovf = tick && (cnt == modv); // R7 R10
		next_pre = pre + 7'h01;
		next_ps = ps;
		next_modv = modv;
		// value the counter takes on a tick; compare acts as the counter reaches it
		cnt_step = ovf ? timer_channel_pkg::CNT_RESET : cnt + 16'h0001; // R10
		next_cnt = cnt;
		if (tick) begin
			next_cnt = cnt_step; // R10
		end
		if (bus.wr && bus.addr == timer_channel_pkg::TIMER_CTL_ADDR) begin
			next_ps = bus.wdata[timer_channel_pkg::PS_LSB +: 3];
			if (bus.wdata[timer_channel_pkg::CNT_RST_BIT]) begin
				next_cnt = timer_channel_pkg::CNT_RESET;
				next_pre = timer_channel_pkg::PRE_RESET;
			end
		end
		if (bus.wr && bus.addr == timer_channel_pkg::MOD_HI_ADDR) begin
			next_modv[15:8] = bus.wdata;
		end
		if (bus.wr && bus.addr == timer_channel_pkg::MOD_LO_ADDR) begin
			next_modv[7:0] = bus.wdata;
		end

		// pin filter: a level counts once the two late stages agree
		next_st = st;
		for (int i = 0; i < 2; i++) begin
			if (s2[i] == s3[i]) begin
				next_st[i] = s3[i];
			end
		end
		rise = s2 & s3 & ~st;
		fall = ~s2 & ~s3 & st;

		// linked pair bookkeeping
		linked = ctl[0].buffered_mode_select; // R1
		next_active = active;
		next_last_wr = last_wr;
		if (!linked) begin
			next_active = 1'b0; // R2
			next_last_wr = 1'b0;
		end else if (ovf) begin
			next_active = last_wr; // R2 R3
		end

		for (int i = 0; i < 2; i++) begin
			// channel 1 is idle while linked
			en[i] = !(i == 1 && linked); // R4
			ccv_eff[i] = (i == 0 && linked && active) ? ccv[1] : ccv[i]; // R2 R5
			match[i] = en[i] && ctl[i].mode_compare && tick && (cnt_step == ccv_eff[i]); // R13 R8
			cap[i] = en[i] && !ctl[i].mode_compare
				&& ((ctl[i].edge_a && rise[i]) || (ctl[i].edge_b && fall[i])); // R12
			evt[i] = match[i] || cap[i];
			next_ctl[i] = ctl[i];
			next_ccv[i] = ccv[i];
			next_arm[i] = arm[i];

			// software access to channel status and control
			if (bus.rd && bus.addr == 4'(timer_channel_pkg::CH0_SC_ADDR + CH_OFS(i))
				&& ctl[i].channel_event_flag) begin
				next_arm[i] = 1'b1; // R14
			end
			if (bus.wr && bus.addr == 4'(timer_channel_pkg::CH0_SC_ADDR + CH_OFS(i))) begin
				next_ctl[i] = bus.wdata; // R17 R16
				next_ctl[i].channel_event_flag = ctl[i].channel_event_flag; // R15
				if (i == 1) begin
					next_ctl[i].buffered_mode_select = 1'b0;
				end
				if (!bus.wdata[7] && arm[i]) begin
					next_ctl[i].channel_event_flag = 1'b0; // R14
				end
				next_arm[i] = 1'b0;
			end
			if (bus.wr && bus.addr == 4'(timer_channel_pkg::CH0_HI_ADDR + CH_OFS(i))) begin
				next_ccv[i][15:8] = bus.wdata; // R5
			end
			if (bus.wr && bus.addr == 4'(timer_channel_pkg::CH0_LO_ADDR + CH_OFS(i))) begin
				next_ccv[i][7:0] = bus.wdata; // R5
			end
			if (linked && bus.wr && (bus.addr == 4'(timer_channel_pkg::CH0_HI_ADDR + CH_OFS(i))
				|| bus.addr == 4'(timer_channel_pkg::CH0_LO_ADDR + CH_OFS(i)))) begin
				next_last_wr = (i == 1); // R3
			end
			if (cap[i]) begin
				next_ccv[i] = cnt; // capture latches the counter
			end
			// a new event wins over the clear and voids the pending read
			if (evt[i]) begin
				next_ctl[i].channel_event_flag = 1'b1; // R12 R13 R14
				next_arm[i] = 1'b0; // R14
			end

			// pin driver for compare and PWM
			next_pin_oe[i] = en[i] && ctl[i].mode_compare
				&& (ctl[i].edge_a || ctl[i].edge_b); // R4 R1
			next_pin_out[i] = channel_pin_out[i];
			if (ctl[i].full_duty) begin
				if (ovf) begin
					next_pin_out[i] = ctl[i].edge_b && !ctl[i].edge_a; // R17
				end
			end else begin
				if (ovf && ctl[i].toggle_on_overflow) begin
					next_pin_out[i] = !channel_pin_out[i]; // R7
				end
				if (match[i]) begin
					case ({ctl[i].edge_b, ctl[i].edge_a})
						2'b01: next_pin_out[i] = !channel_pin_out[i];
						2'b10: next_pin_out[i] = 1'b0; // R8 R11
						2'b11: next_pin_out[i] = 1'b1; // R8
						default: next_pin_out[i] = channel_pin_out[i];
					endcase
				end
			end
			next_irq[i] = next_ctl[i].channel_event_flag
				&& next_ctl[i].channel_interrupt_enable; // R18 R16
		end

		// read data stand only in the cycle after the strobe
		next_rdata = timer_channel_pkg::RDATA_IDLE;
		if (bus.rd) begin
			case (bus.addr)
				timer_channel_pkg::TIMER_CTL_ADDR: next_rdata = {5'h00, ps};
				timer_channel_pkg::CNT_HI_ADDR: next_rdata = cnt[15:8];
				timer_channel_pkg::CNT_LO_ADDR: next_rdata = cnt[7:0];
				timer_channel_pkg::MOD_HI_ADDR: next_rdata = modv[15:8];
				timer_channel_pkg::MOD_LO_ADDR: next_rdata = modv[7:0];
				timer_channel_pkg::CH0_SC_ADDR: next_rdata = ctl[0];
				timer_channel_pkg::CH0_HI_ADDR: next_rdata = ccv[0][15:8];
				timer_channel_pkg::CH0_LO_ADDR: next_rdata = ccv[0][7:0];
				4'(timer_channel_pkg::CH0_SC_ADDR + timer_channel_pkg::CH_STRIDE):
					next_rdata = ctl[1];
				4'(timer_channel_pkg::CH0_HI_ADDR + timer_channel_pkg::CH_STRIDE):
					next_rdata = ccv[1][15:8];
				4'(timer_channel_pkg::CH0_LO_ADDR + timer_channel_pkg::CH_STRIDE):
					next_rdata = ccv[1][7:0];
				default: next_rdata = timer_channel_pkg::RDATA_IDLE;
			endcase
		end
	end

	// channel register offset from channel 0
	function automatic logic [3:0] CH_OFS(input int idx);
		CH_OFS = (idx == 1) ? timer_channel_pkg::CH_STRIDE : 4'h0;
	endfunction : CH_OFS

	// ********************************
	// registers
	// ********************************
	always_ff @(posedge clk_sys) begin
		// synchroniser stages run freely
		s1 <= channel_pin_in;
		s2 <= s1;
		s3 <= s2;
		if (reset) begin
			pre <= timer_channel_pkg::PRE_RESET;
			ps <= timer_channel_pkg::PS_RESET;
			cnt <= timer_channel_pkg::CNT_RESET;
			modv <= timer_channel_pkg::MOD_RESET;
			ctl[0] <= timer_channel_pkg::CTL_RESET; // R15 R16
			ctl[1] <= timer_channel_pkg::CTL_RESET;
			ccv[0] <= timer_channel_pkg::CCV_RESET;
			ccv[1] <= timer_channel_pkg::CCV_RESET;
			arm <= 2'h0;
			active <= 1'b0;
			last_wr <= 1'b0;
			st <= 2'h0;
			channel_pin_out <= 2'h0;
			channel_pin_oe <= 2'h0;
			irq <= 2'h0;
			rdata <= timer_channel_pkg::RDATA_IDLE;
		end else begin
			pre <= next_pre;
			ps <= next_ps;
			cnt <= next_cnt;
			modv <= next_modv;
			ctl[0] <= next_ctl[0];
			ctl[1] <= next_ctl[1];
			ccv[0] <= next_ccv[0];
			ccv[1] <= next_ccv[1];
			arm <= next_arm;
			active <= next_active;
			last_wr <= next_last_wr;
			st <= next_st;
			channel_pin_out <= next_pin_out;
			channel_pin_oe <= next_pin_oe;
			irq <= next_irq;
			rdata <= next_rdata;
		end
	end

	// ********************************
	// checks
	// ********************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	property p_match_flag;
		match[0] |=> ctl[0].channel_event_flag;
	endproperty
	a_match_flag: assert property (p_match_flag) else $error("compare match lost"); // R13

	property p_capture_flag;
		cap[1] |=> ctl[1].channel_event_flag && ccv[1] == $past(cnt);
	endproperty
	a_capture_flag: assert property (p_capture_flag) else $error("capture lost"); // R12

	property p_write_one;
		bus.wr && bus.addr == timer_channel_pkg::CH0_SC_ADDR && bus.wdata[7]
			&& !ctl[0].channel_event_flag && !evt[0] |=> !ctl[0].channel_event_flag;
	endproperty
	a_write_one: assert property (p_write_one) else $error("write 1 set flag"); // R15

	property p_clear_seq;
		ctl[0].channel_event_flag && bus.rd && bus.addr == timer_channel_pkg::CH0_SC_ADDR
			&& !evt[0]
			##1 (!evt[0] && bus.wr && bus.addr == timer_channel_pkg::CH0_SC_ADDR
			&& !bus.wdata[7]) |=> !ctl[0].channel_event_flag;
	endproperty
	a_clear_seq: assert property (p_clear_seq) else $error("flag not cleared"); // R14

	property p_event_wins;
		evt[0] |=> ctl[0].channel_event_flag && !arm[0];
	endproperty
	a_event_wins: assert property (p_event_wins) else $error("event lost"); // R14

	property p_irq;
		irq[1] == (ctl[1].channel_event_flag && ctl[1].channel_interrupt_enable);
	endproperty
	a_irq: assert property (p_irq) else $error("irq mismatch"); // R18

	property p_handover;
		linked && ovf && ctl[0].buffered_mode_select ##1 ctl[0].buffered_mode_select
			|-> active == $past(last_wr);
	endproperty
	a_handover: assert property (p_handover) else $error("wrong active channel"); // R3

	property p_ch1_released;
		linked |=> !channel_pin_oe[1];
	endproperty
	a_ch1_released: assert property (p_ch1_released) else $error("ch1 pin driven"); // R4

	property p_ovf_toggle;
		ovf && ctl[0].toggle_on_overflow && !ctl[0].full_duty && !match[0]
			|=> channel_pin_out[0] != $past(channel_pin_out[0]);
	endproperty
	a_ovf_toggle: assert property (p_ovf_toggle) else $error("no overflow toggle"); // R7

	property p_clear_on_match;
		match[0] && !ctl[0].full_duty && ctl[0].edge_b && !ctl[0].edge_a
			|=> !channel_pin_out[0];
	endproperty
	a_clear_on_match: assert property (p_clear_on_match) else $error("pin not cleared"); // R8

	property p_wrap;
		ovf |=> cnt == timer_channel_pkg::CNT_RESET;
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter did not wrap"); // R10

endmodule : timer_channel_compare_pwm

`default_nettype wire

// >>> rtl/timer_channel_pkg.sv
// Purpose: shared constants and types for the two-channel timer block
// Assumes: 8-bit register port, 4-bit register address
// Notes: all offsets, register reset values and bit positions live here

package timer_channel_pkg;

	// ********************************
	// register offsets
	// ********************************
	localparam logic [3:0] TIMER_CTL_ADDR = 4'h0;
	localparam logic [3:0] CNT_HI_ADDR = 4'h1;
	localparam logic [3:0] CNT_LO_ADDR = 4'h2;
	localparam logic [3:0] MOD_HI_ADDR = 4'h3;
	localparam logic [3:0] MOD_LO_ADDR = 4'h4;
	localparam logic [3:0] CH0_SC_ADDR = 4'h5;
	localparam logic [3:0] CH0_HI_ADDR = 4'h6;
	localparam logic [3:0] CH0_LO_ADDR = 4'h7;
	localparam logic [3:0] CH_STRIDE = 4'h3;

	// ********************************
	// field positions and reset values
	// ********************************
	localparam int PS_LSB = 0;
	localparam int CNT_RST_BIT = 4;
	localparam logic [2:0] PS_RESET = 3'h0;
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [15:0] MOD_RESET = 16'hffff;
	localparam logic [15:0] CCV_RESET = 16'h0000;
	localparam logic [6:0] PRE_RESET = 7'h00;
	localparam logic [7:0] RDATA_IDLE = 8'h00;

	// channel status and control layout, bit 7 down to bit 0
	typedef struct packed {
		logic channel_event_flag;
		logic channel_interrupt_enable;
		logic buffered_mode_select;
		logic mode_compare;
		logic edge_b;
		logic edge_a;
		logic toggle_on_overflow;
		logic full_duty;
	} chan_ctl_t;

	localparam chan_ctl_t CTL_RESET = 8'h00;

	// one register access from software
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

endpackage : timer_channel_pkg

// >>> sim/pin_partner.sv
// Purpose: external circuitry on the two channel pins
// Assumes: a released pin is driven by the outside source
// Notes: the resolved level is what the block's pin inputs see

`timescale 1ns/1ps
`default_nettype none

module pin_partner (
	// design side
	input wire logic [1:0] pin_out,
	input wire logic [1:0] pin_oe,
	// outside source
	input wire logic [1:0] ext_level,
	// resolved pin levels
	output logic [1:0] pin_wire
);
	// ********************************
	// pin resolution
	// ********************************
	// driven pin shows the block, released pin shows the outside source
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			pin_wire[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
		end
	end
endmodule : pin_partner

`default_nettype wire

// >>> sim/tb_timer_channel_compare_pwm.sv
// Purpose: self-checking bench for the two-channel timer block
// Assumes: 10 MHz clk_sys, synchronous active-high reset
// Notes: register rows first, then reset, PWM, capture, linked and output mode cases

`timescale 1ns/1ps
`default_nettype none

module tb_timer_channel_compare_pwm;
	logic clk_sys;
	logic reset;
	timer_channel_pkg::bus_req_t bus;
	logic [7:0] rdata;
	logic [1:0] pin_out;
	logic [1:0] pin_oe;
	logic [1:0] irq;
	logic [1:0] ext_level;
	logic [1:0] pin_wire;
	logic [7:0] rd_val;
	int err_total;
	int n_checks;
	int w;
	// address, write data, expected read back
	logic [23:0] rows [12] = '{24'h601212, 24'h703434, 24'h905656, 24'ha07878,
		24'h300000, 24'h40ffff, 24'h508000, 24'h504040, 24'h802000, 24'hb05a00,
		24'h001303, 24'h000000};

	timer_channel_compare_pwm uut (.clk_sys(clk_sys), .reset(reset), .bus(bus),
		.rdata(rdata), .channel_pin_in(pin_wire), .channel_pin_out(pin_out),
		.channel_pin_oe(pin_oe), .irq(irq));
	pin_partner u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
		.pin_wire(pin_wire));

	// ********************************
	// shared tasks
	// ********************************
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus.wr <= 1'b0;
	endtask : wr_reg

	// read data stand only in the cycle after the strobe; taken at the edge ending it
	task automatic rd_reg(input logic [3:0] a);
		@(posedge clk_sys);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus.rd <= 1'b0;
		@(posedge clk_sys);
		rd_val = rdata;
	endtask : rd_reg

	// cycles until channel 0 pin reaches a level, bounded
	task automatic wait_pin(input logic lvl, output int n);
		n = 0;
		do begin
			@(posedge clk_sys);
			#1 n++;
		end while (pin_wire[0] !== lvl && n < 1000);
	endtask : wait_pin

	task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
		rd_reg(a);
		check(what, {8'h00, rd_val}, {8'h00, exp});
	endtask : rd_chk

	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : conclude

	// ********************************
	// clock, watchdog and tests
	// ********************************
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// all tests take well under 7000 cycles
	initial begin
		repeat (20000) @(posedge clk_sys);
		err_total++;
		conclude();
	end

	initial begin
		reset = 1'b1;
		bus = '0;
		ext_level = 2'b00;
		err_total = 0;
		n_checks = 0;
		repeat (10) @(posedge clk_sys);
		reset <= 1'b0;
		foreach (rows[i]) begin
			wr_reg(rows[i][23:20], rows[i][15:8]);
			rd_chk("row", rows[i][23:20], rows[i][7:0]);
		end
		$display("test registers done");
		reset <= 1'b1;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		rd_chk("ch0 ctl", timer_channel_pkg::CH0_SC_ADDR, 8'h00);
		rd_chk("mod hi", timer_channel_pkg::MOD_HI_ADDR, 8'hff);
		check("irq", {14'h0, irq}, 16'h0000);
		$display("test reset done");
		// 8-bit PWM, high pulse by clear on compare
		wr_reg(4'h3, 8'h00);
		wr_reg(4'h4, 8'hff);
		wr_reg(4'h7, 8'h80);
		wr_reg(4'h5, 8'h5a);
		wr_reg(4'h0, 8'h10);
		wait_pin(1'b1, w);
		wait_pin(1'b0, w);
		check("width", w[15:0], 16'h0080);
		check("irq", {14'h0, irq}, 16'h0001);
		check("oe0", {15'h0, pin_oe[0]}, 16'h0001);
		wait_pin(1'b1, w);
		check("low", w[15:0], 16'h0080);
		rd_chk("flag", 4'h5, 8'hda);
		wr_reg(4'h5, 8'h5a);
		rd_chk("cleared", 4'h5, 8'h5a);
		check("irq", {14'h0, irq}, 16'h0000);
		wr_reg(4'h5, 8'h1a);
		wait_pin(1'b0, w);
		check("masked", {14'h0, irq}, 16'h0000);
		rd_chk("flag", 4'h5, 8'h9a);
		$display("test pwm done");
		// capture on channel 1, rising then any edge
		wr_reg(4'h8, 8'h44);
		ext_level <= 2'b10;
		repeat (8) @(posedge clk_sys);
		rd_chk("rise", 4'h8, 8'hc4);
		check("irq1", {14'h0, irq}, 16'h0002);
		wr_reg(4'h8, 8'h04);
		ext_level <= 2'b00;
		repeat (8) @(posedge clk_sys);
		rd_chk("fall", 4'h8, 8'h04);
		wr_reg(4'h8, 8'h0c);
		ext_level <= 2'b10;
		repeat (8) @(posedge clk_sys);
		rd_chk("any", 4'h8, 8'h8c);
		ext_level <= 2'b00;
		repeat (8) @(posedge clk_sys);
		wr_reg(4'h8, 8'h0c);
		rd_chk("kept", 4'h8, 8'h8c);
		$display("test capture done");
		// linked pair: channel 0 first, then last written at each overflow
		wr_reg(4'h5, 8'h3a);
		wr_reg(4'h7, 8'h40);
		wait_pin(1'b1, w);
		wait_pin(1'b0, w);
		check("ch0 width", w[15:0], 16'h0040);
		check("oe1", {15'h0, pin_oe[1]}, 16'h0000);
		wr_reg(4'h9, 8'h00);
		wr_reg(4'ha, 8'hc0);
		wait_pin(1'b1, w);
		wait_pin(1'b0, w);
		check("ch1 width", w[15:0], 16'h00c0);
		wr_reg(4'h7, 8'h20);
		wait_pin(1'b1, w);
		wait_pin(1'b0, w);
		check("back width", w[15:0], 16'h0020);
		$display("test linked done");
		// unlinked set on compare with overflow toggle gives a low pulse
		wr_reg(4'h5, 8'h1e);
		wait_pin(1'b1, w);
		wait_pin(1'b0, w);
		wait_pin(1'b1, w);
		check("low pulse", w[15:0], 16'h0020);
		// toggle on compare alone gives one edge per period
		wr_reg(4'h5, 8'h14);
		wait_pin(1'b0, w);
		wait_pin(1'b1, w);
		check("toggle", w[15:0], 16'h0100);
		// forced full duty holds the pin past the bounded wait
		wr_reg(4'h5, 8'h19);
		wait_pin(1'b1, w);
		wait_pin(1'b0, w);
		check("full high", w[15:0], 16'h03e8);
		wr_reg(4'h5, 8'h1d);
		wait_pin(1'b0, w);
		wait_pin(1'b1, w);
		check("full low", w[15:0], 16'h03e8);
		$display("test modes done");
		conclude();
	end
endmodule : tb_timer_channel_compare_pwm

`default_nettype wire
